// [network_clock_manager.sv]
// Clock manager: reference select, master clock divider, lock and sleep
`timescale 1ns/10ps
module network_clock_manager
    import clkmgr_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       RST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic       RX_LINE,
    input  wire logic       PLL_LOCK_IN,
    input  wire logic       PLL_TICK,
    input  wire logic       NET_WAKE,
    input  wire logic       FRAME_SYNC,
    input  wire logic       RECOVERED_MASTER_CLK_EN,
    input  wire logic       ALL_BYPASS_SEL,
    input  wire logic       SRC_BYPASS_SEL,
    input  wire logic       LOCK_ERR_CLR,
    output logic      [1:0] PLL_REF_SEL,
    output logic            PLL_HOLD_OFF,
    output logic            OSC_POWER_EN,
    output logic      [1:0] OSC_RATIO_SEL,
    output logic            RECOVERED_MASTER_CLK,
    output logic      [7:0] PWD_TUNE,
    output logic            LINE_ACTIVITY,
    output logic            PLL_UNLOCKED,
    output logic            LOCK_ERR,
    output logic            SRC_XFER_EN,
    output logic            LIGHT_SLEEP,
    output logic            DEEP_SLEEP
);

    // Base ticks per master clock period, base rate is 3072 Fs
    function automatic logic [5:0] div_limit(input logic [2:0] code);
        case (code)
            3'b000:  div_limit = 6'd8;
            3'b001:  div_limit = 6'd12;
            3'b010:  div_limit = 6'd24;
            3'b011:  div_limit = 6'd48;
            3'b100:  div_limit = 6'd2;
            3'b101:  div_limit = 6'd3;
            3'b110:  div_limit = 6'd4;
            default: div_limit = 6'd6;
        endcase
    endfunction

    state_t     s_r;
    state_t     s_nxt;
    logic       rx_edge;
    logic       tick;
    logic       host_acc;
    logic       wr_cm1;
    logic       wr_cm2;
    logic [5:0] lim;
    logic [5:0] high_len;

    assign rx_edge  = s_r.rx_sy[1] ^ s_r.rx_sy[2];
    assign tick     = s_r.tk_sy[1] & ~s_r.tk_sy[2];
    assign host_acc = REG_WR | REG_RD;
    assign wr_cm1   = REG_WR && (REG_ADDR == CM1_ADDR);
    assign wr_cm2   = REG_WR && (REG_ADDR == CM2_ADDR);

    always_comb begin
        s_nxt = s_r;

        // Pin synchronisers
        s_nxt.rx_sy = {s_r.rx_sy[1:0], RX_LINE};
        s_nxt.lk_sy = {s_r.lk_sy[0], PLL_LOCK_IN};
        s_nxt.tk_sy = {s_r.tk_sy[1:0], PLL_TICK};

        // Receive line activity, retriggered by either edge
        if (rx_edge) begin
            s_nxt.act_cnt = 3'(ACT_HOLD_CYC);
        end else if (s_r.act_cnt != 3'h0) begin
            s_nxt.act_cnt = s_r.act_cnt - 3'h1;
        end

        // Lock status and sticky lock error, set beats clear
        s_nxt.unlock = ~s_r.lk_sy[1];
        if (LOCK_ERR_CLR) begin
            s_nxt.lock_err = 1'b0;
        end
        if (!s_r.unlock && s_nxt.unlock) begin
            s_nxt.lock_err = 1'b1;
        end

        // Frames since lock, restarted by any unlock
        if (s_r.unlock) begin
            s_nxt.frame_cnt = 2'h0;
        end else if (FRAME_SYNC && s_r.frame_cnt != SYNC_FRAMES) begin
            s_nxt.frame_cnt = s_r.frame_cnt + 2'h1;
        end

        // Sleep sequencing; waking drops both enables
        case (s_r.slp)
            AWAKE: begin
                if (s_r.deep_en || s_r.light_en) begin
                    s_nxt.slp = LIGHT;
                end
            end
            LIGHT: begin
                if (host_acc || NET_WAKE) begin
                    s_nxt.slp      = AWAKE;
                    s_nxt.deep_en  = 1'b0;
                    s_nxt.light_en = 1'b0;
                end else if (s_r.deep_en && s_r.act_cnt == 3'h0) begin
                    s_nxt.slp = DEEP;
                end
            end
            DEEP: begin
                if (host_acc || s_r.act_cnt != 3'h0) begin
                    s_nxt.slp      = AWAKE;
                    s_nxt.deep_en  = 1'b0;
                    s_nxt.light_en = 1'b0;
                end
            end
            default: begin
                s_nxt.slp = AWAKE;
            end
        endcase

        // Register writes act on the next cycle
        if (wr_cm1) begin
            s_nxt.cm1 = REG_WDATA;
            if (REG_WDATA[RATIO_LSB +: 2] == RATIO_RSVD) begin
                s_nxt.cm1[RATIO_LSB +: 2] = s_r.cm1[RATIO_LSB +: 2];
            end
        end
        if (wr_cm2) begin
            s_nxt.deep_en  = REG_WDATA[DEEP_BIT];
            s_nxt.light_en = REG_WDATA[LIGHT_BIT];
        end
        if (REG_WR && REG_ADDR == TUNE_ADDR) begin
            s_nxt.tune = REG_WDATA;
        end

        // Master clock divider; a new ratio restarts it
        lim      = div_limit(s_nxt.cm1[DIV_LSB +: 3]);
        high_len = lim >> 1;
        if (s_nxt.cm1[DIV_LSB +: 3] != s_r.cm1[DIV_LSB +: 3]) begin
            s_nxt.div_cnt = 6'h0;
        end else if (tick) begin
            if (s_r.div_cnt >= lim - 6'h1) begin
                s_nxt.div_cnt = 6'h0;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 6'h1;
            end
        end
        s_nxt.recovered_master_clk = RECOVERED_MASTER_CLK_EN && (s_nxt.div_cnt < high_len);

        // Read data, served in any sleep or lock state
        s_nxt.rdata = 8'h00;
        if (REG_RD) begin
            case (REG_ADDR)
                CM1_ADDR: begin
                    s_nxt.rdata = s_r.cm1;
                end
                CM2_ADDR: begin
                    s_nxt.rdata[UNLOCK_BIT] = s_r.unlock;
                    s_nxt.rdata[ACT_BIT]    = s_r.act_cnt != 3'h0;
                    s_nxt.rdata[DEEP_BIT]   = s_r.deep_en;
                    s_nxt.rdata[LIGHT_BIT]  = s_r.light_en;
                end
                TUNE_ADDR: begin
                    s_nxt.rdata = s_r.tune;
                end
                default: begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            s_r           <= '0;
            s_r.cm1       <= CM1_RST;
            s_r.tune      <= TUNE_RST;
            s_r.slp       <= AWAKE;
            s_r.unlock    <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign REG_RDATA            = s_r.rdata;
    assign PLL_REF_SEL          = s_r.cm1[SRC_LSB +: 2];
    assign PLL_HOLD_OFF         = s_r.cm1[HOLD_OFF_BIT];
    assign OSC_POWER_EN         = s_r.cm1[SRC_LSB +: 2] == SRC_XTAL;
    assign OSC_RATIO_SEL        = s_r.cm1[RATIO_LSB +: 2];
    assign RECOVERED_MASTER_CLK = s_r.recovered_master_clk;
    assign PWD_TUNE             = s_r.tune;
    assign LINE_ACTIVITY        = s_r.act_cnt != 3'h0;
    assign PLL_UNLOCKED         = s_r.unlock;
    assign LOCK_ERR             = s_r.lock_err;
    assign SRC_XFER_EN          = !s_r.unlock && (ALL_BYPASS_SEL
        || SRC_BYPASS_SEL || s_r.frame_cnt == SYNC_FRAMES);
    assign LIGHT_SLEEP          = s_r.slp == LIGHT;
    assign DEEP_SLEEP           = s_r.slp == DEEP;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    AST_REF_SEL:
    assert property (wr_cm1 |=> PLL_REF_SEL == $past(REG_WDATA[1:0]))
        else $error("Lock source select not taken from write");

    AST_HOLD_OFF:
    assert property (wr_cm1 && REG_WDATA[7] |=> PLL_HOLD_OFF)
        else $error("Hold-off not applied");

    AST_RATIO_RSVD:
    assert property (wr_cm1 && REG_WDATA[3:2] == 2'h3
        |=> $stable(OSC_RATIO_SEL))
        else $error("Reserved oscillator ratio was stored");

    AST_OSC_PWR:
    assert property (OSC_POWER_EN == (PLL_REF_SEL == 2'h2))
        else $error("Oscillator power does not follow source");

    AST_UNLOCK_RD:
    assert property (REG_RD && REG_ADDR == 8'h8E
        |=> REG_RDATA[7] == $past(PLL_UNLOCKED) && REG_RDATA[3:0] == 4'h0)
        else $error("Clock status read wrong");

    AST_ACT_HOLD:
    assert property (rx_edge |=> LINE_ACTIVITY [*4])
        else $error("Line activity hold time wrong");

    AST_ACT_CLEAR:
    assert property (rx_edge ##1 !rx_edge [*4] |=> !LINE_ACTIVITY)
        else $error("Line activity outlived its hold");

    AST_LOCK_ERR:
    assert property ($rose(PLL_UNLOCKED) |-> LOCK_ERR)
        else $error("Loss of lock not captured");

    AST_NO_XFER:
    assert property (PLL_UNLOCKED |-> !SRC_XFER_EN)
        else $error("Source data enabled while unlocked");

    AST_THREE_FRAMES:
    assert property ($fell(PLL_UNLOCKED) && !ALL_BYPASS_SEL
        && !SRC_BYPASS_SEL |-> !SRC_XFER_EN)
        else $error("Source data enabled before three frames");

    AST_DEEP_WAKE:
    assert property (DEEP_SLEEP && LINE_ACTIVITY |=> !DEEP_SLEEP)
        else $error("Deep sleep ignored line activity");

    AST_LIGHT_WAKE:
    assert property (LIGHT_SLEEP && NET_WAKE |=> !LIGHT_SLEEP
        && !DEEP_SLEEP)
        else $error("Light sleep ignored wake-up");

    AST_DUTY_THIRD:
    assert property (RECOVERED_MASTER_CLK_EN && $stable(RECOVERED_MASTER_CLK_EN)
        && s_r.cm1[6:4] == 3'b101 && $stable(s_r.cm1[6:4])
        && s_r.div_cnt != 6'h0 |-> !RECOVERED_MASTER_CLK)
        else $error("Third duty cycle wrong");

    AST_DUTY_THIRD_HIGH:
    assert property (RECOVERED_MASTER_CLK_EN && $stable(RECOVERED_MASTER_CLK_EN)
        && s_r.cm1[6:4] == 3'b101 && $stable(s_r.cm1[6:4])
        && s_r.div_cnt == 6'h0 |-> RECOVERED_MASTER_CLK)
        else $error("Third duty high phase missing");

    // Output gate and divider sequencing
    AST_RECOVERED_MASTER_CLK_OFF:
    assert property (!RECOVERED_MASTER_CLK_EN |=> !RECOVERED_MASTER_CLK)
        else $error("Master clock ran while disabled");

    AST_DUTY_HALF:
    assert property (RECOVERED_MASTER_CLK_EN && $stable(RECOVERED_MASTER_CLK_EN)
        && s_r.cm1[6:4] == 3'b100 && s_r.div_cnt == 6'h0
        |-> RECOVERED_MASTER_CLK)
        else $error("Half duty high phase missing");

    AST_DIV_WRAP:
    assert property (tick && s_r.div_cnt == 6'h1
        && s_r.cm1[6:4] == 3'b100 |=> s_r.div_cnt == 6'h0)
        else $error("Divider did not wrap");

    AST_DIV_RESTART:
    assert property (wr_cm1 && REG_WDATA[6:4] != s_r.cm1[6:4]
        |=> s_r.div_cnt == 6'h0)
        else $error("Divider not restarted on new ratio");

    // Register fields follow writes; reads return status, idle read data is zero
    AST_HOLD_CLEAR:
    assert property (wr_cm1 && !REG_WDATA[7] |=> !PLL_HOLD_OFF)
        else $error("Hold-off not released");

    AST_RATIO_WR:
    assert property (wr_cm1 && REG_WDATA[3:2] != 2'h3
        |=> OSC_RATIO_SEL == $past(REG_WDATA[3:2]))
        else $error("Oscillator ratio not taken from write");

    AST_TUNE_WR:
    assert property (REG_WR && REG_ADDR == 8'h93 |=> PWD_TUNE == $past(REG_WDATA))
        else $error("Tuning value not taken from write");

    AST_RD_IDLE:
    assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("Read data not idle");

    AST_ACT_RD:
    assert property (REG_RD && REG_ADDR == 8'h8E
        |=> REG_RDATA[6] == $past(LINE_ACTIVITY))
        else $error("Activity flag read wrong");

    // Lock tracking
    AST_UNLOCK_FOLLOW:
    assert property (s_r.lk_sy[1] |=> !PLL_UNLOCKED)
        else $error("Unlock flag stayed set while locked");

    AST_LOCK_ERR_STICKY:
    assert property (LOCK_ERR && !LOCK_ERR_CLR |=> LOCK_ERR)
        else $error("Lock error flag not sticky");

    AST_LOCK_ERR_CLR:
    assert property (LOCK_ERR_CLR && (PLL_UNLOCKED || s_r.lk_sy[1])
        |=> !LOCK_ERR)
        else $error("Lock error flag not cleared");

    AST_XFER_THIRD:
    assert property (!PLL_UNLOCKED && FRAME_SYNC && s_r.frame_cnt == 2'h2
        |=> SRC_XFER_EN || PLL_UNLOCKED)
        else $error("Source data not enabled after third frame");

    // Sleep sequencing
    AST_SLEEP_ENTER:
    assert property (wr_cm2 && REG_WDATA[4] ##1 !REG_WR && !REG_RD
        && !NET_WAKE |=> LIGHT_SLEEP || DEEP_SLEEP)
        else $error("Light sleep not entered");

    AST_LIGHT_HOST:
    assert property (LIGHT_SLEEP && (REG_WR || REG_RD) |=> !LIGHT_SLEEP
        && !DEEP_SLEEP)
        else $error("Light sleep ignored host access");

    AST_DEEP_ENTER:
    assert property (LIGHT_SLEEP && s_r.deep_en && !LINE_ACTIVITY
        && !REG_WR && !REG_RD && !NET_WAKE |=> DEEP_SLEEP)
        else $error("Deep sleep not entered on quiet line");

endmodule

// [clkmgr_pkg.sv]
// Constants and types of the network clock manager
// Notes on behaviour
// - Lock source select picks reference: 00 line, 01 audio, 10 crystal, 11 bit clock
// - Hold-off bit 7 stops locking; PLL falls to lowest frequency
// - Divider field sets master clock multiple: 384,256,128,64,1536,1024,768,512
// - Divider code 101 gives one third duty cycle
// - Oscillator ratio 00 256x, 01 384x, 10 512x; 11 reserved
// - Unlock flag bit 7 reads 1 unlocked, 0 locked; 1 after reset
// - Line activity set by receive edges, clears about 128 ns after them
// - Deep-sleep bit 5: light sleep, deep once quiet; wake on activity or access
// - Light-sleep bit 4: light sleep; wake on host access or network wake
// - Tolerance tuning register resets to C0h; host loads C0h or C3h
// - Loss of lock sets sticky error flag until software clears it
// - After lock, source data needs three frames unless bypassed
// - No source data while unlocked; register access always served
// - Crystal oscillator powered down unless lock source select is 10
// - Divider change or unlock may glitch master clock output
// - Unlocked PLL drifts to lowest frequency but still clocks
package clkmgr_pkg;

    localparam logic [7:0] CM1_ADDR   = 8'h83;
    localparam logic [7:0] CM2_ADDR   = 8'h8E;
    localparam logic [7:0] TUNE_ADDR  = 8'h93;

    localparam int HOLD_OFF_BIT       = 7;
    localparam int DIV_LSB            = 4;
    localparam int RATIO_LSB          = 2;
    localparam int SRC_LSB            = 0;
    localparam int UNLOCK_BIT         = 7;
    localparam int ACT_BIT            = 6;
    localparam int DEEP_BIT           = 5;
    localparam int LIGHT_BIT          = 4;

    localparam logic [7:0] CM1_RST    = 8'h00;
    localparam logic [7:0] TUNE_RST   = 8'hC0;
    localparam logic [1:0] SRC_LINE   = 2'h0;
    localparam logic [1:0] SRC_XTAL   = 2'h2;
    localparam logic [1:0] RATIO_RSVD = 2'h3;

    localparam int CLK_PERIOD_NS      = 40;
    localparam int ACT_HOLD_NS        = 128;
    localparam int ACT_HOLD_CYC =
        (ACT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] SYNC_FRAMES = 2'h3;

    typedef enum logic [1:0] {
        AWAKE = 2'b00,
        LIGHT = 2'b01,
        DEEP  = 2'b11
    } sleep_t;

    typedef struct packed {
        logic [7:0] cm1;
        logic       deep_en;
        logic       light_en;
        logic [7:0] tune;
        sleep_t     slp;
        logic [2:0] rx_sy;
        logic [1:0] lk_sy;
        logic [2:0] tk_sy;
        logic [2:0] act_cnt;
        logic       unlock;
        logic       lock_err;
        logic [1:0] frame_cnt;
        logic [5:0] div_cnt;
        logic       recovered_master_clk;
        logic [7:0] rdata;
    } state_t;

endpackage

// [net_far_side.sv]
// Far-side model: network receive line and analogue PLL indications
`timescale 1ns/10ps
module net_far_side (
    input  wire logic MCLK,
    input  wire logic act_on,
    input  wire logic lock_on,
    output logic      rx_line,
    output logic      pll_lock,
    output logic      pll_tick
);
    logic [1:0] tick_cnt;
    initial begin
        tick_cnt = 2'h0;
        rx_line  = 1'b0;
    end
    // Line edges only while the network is active
    always @(posedge MCLK) begin
        tick_cnt <= tick_cnt + 2'h1;
        if (act_on) begin
            rx_line <= ~rx_line;
        end
    end
    // Base clock keeps running when unlocked, under MCLK/2
    assign pll_tick = tick_cnt[1];
    assign pll_lock = lock_on;
endmodule

// [network_clock_manager_tb_top.sv]
// Self-checking bench for the network clock manager
`timescale 1ns/10ps
module network_clock_manager_tb_top;
    import clkmgr_pkg::*;
    logic       mclk, rst, wr, rd, wake, fsync, clr, act_on, lock_on;
    logic [7:0] addr, wdata, rdata, tune;
    logic [1:0] ref_sel, ratio;
    logic       hold, osc_en, act, unl, lerr, xfer, light, deep;
    logic       rx, lock_in, tick, recovered_master_clk, recovered_master_clk_en;
    int         n_errors = 0;
    int         comparisons = 0;

    network_clock_manager i_dut (
        .MCLK(mclk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RX_LINE(rx),
        .PLL_LOCK_IN(lock_in), .PLL_TICK(tick), .NET_WAKE(wake),
        .FRAME_SYNC(fsync), .RECOVERED_MASTER_CLK_EN(recovered_master_clk_en), .ALL_BYPASS_SEL(1'b0),
        .SRC_BYPASS_SEL(1'b0), .LOCK_ERR_CLR(clr),
        .PLL_REF_SEL(ref_sel), .PLL_HOLD_OFF(hold), .OSC_POWER_EN(osc_en),
        .OSC_RATIO_SEL(ratio), .RECOVERED_MASTER_CLK(recovered_master_clk), .PWD_TUNE(tune),
        .LINE_ACTIVITY(act), .PLL_UNLOCKED(unl), .LOCK_ERR(lerr),
        .SRC_XFER_EN(xfer), .LIGHT_SLEEP(light), .DEEP_SLEEP(deep)
    );
    net_far_side i_far (
        .MCLK(mclk), .act_on(act_on), .lock_on(lock_on),
        .rx_line(rx), .pll_lock(lock_in), .pll_tick(tick)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic frame();
        @(posedge mclk);
        fsync <= 1'b1;
        @(posedge mclk);
        fsync <= 1'b0;
        cyc(2);
    endtask
    // High cycles of the master clock over a 48-cycle window
    task automatic recovered_master_clk_cnt(input logic [7:0] exp);
        logic [7:0] hi;
        hi = 8'h00;
        cyc(16);
        repeat (48) begin
            cyc(1);
            hi = hi + {7'h00, recovered_master_clk};
        end
        chk(hi, exp);
    endtask
    task automatic set_in(input int which, input logic v);
        @(posedge mclk);
        if (which == 0)
            lock_on <= v;
        else if (which == 1)
            act_on <= v;
        else if (which == 2)
            wake <= v;
        else
            clr <= v;
    endtask

    initial begin
        #2000000;
        n_errors++;
        close_out();
    end

    initial begin
        {rst, wr, rd, wake, fsync, clr, act_on, lock_on} = 8'h80;
        addr = 8'h00;
        wdata = 8'h00;
        recovered_master_clk_en = 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk({6'h00, ref_sel}, {6'h00, SRC_LINE});
        chk({6'h00, osc_en, unl}, 8'h01);
        rd_reg(CM1_ADDR, CM1_RST);
        rd_reg(CM2_ADDR, 8'h80);
        rd_reg(TUNE_ADDR, TUNE_RST);
        rd_reg(8'h00, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr_reg(CM1_ADDR, 8'(s));
            chk({6'h00, ref_sel}, 8'(s));
            chk({7'h00, osc_en}, {7'h00, s == 2});
        end
        wr_reg(CM1_ADDR, 8'h92);
        chk({7'h00, hold}, 8'h01);
        rd_reg(CM1_ADDR, 8'h92);
        wr_reg(CM1_ADDR, 8'h04);
        wr_reg(CM1_ADDR, 8'h0C);
        chk({6'h00, ratio}, 8'h01);
        rd_reg(CM1_ADDR, 8'h04);
        wr_reg(CM1_ADDR, 8'h00);
        wr_reg(TUNE_ADDR, 8'hC3);
        chk(tune, 8'hC3);
        set_in(0, 1'b1);
        cyc(6);
        chk({5'h00, unl, xfer, lerr}, 8'h00);
        repeat (2) frame();
        chk({7'h00, xfer}, 8'h00);
        frame();
        chk({7'h00, xfer}, 8'h01);
        set_in(0, 1'b0);
        cyc(6);
        chk({5'h00, unl, xfer, lerr}, 8'h05);
        rd_reg(CM2_ADDR, 8'h80);
        set_in(0, 1'b1);
        cyc(6);
        chk({5'h00, unl, xfer, lerr}, 8'h01);
        set_in(3, 1'b1);
        set_in(3, 1'b0);
        cyc(1);
        chk({7'h00, lerr}, 8'h00);
        set_in(1, 1'b1);
        cyc(8);
        chk({7'h00, act}, 8'h01);
        rd_reg(CM2_ADDR, 8'h40);
        set_in(1, 1'b0);
        cyc(3);
        chk({7'h00, act}, 8'h01);
        cyc(6);
        chk({7'h00, act}, 8'h00);
        wr_reg(CM2_ADDR, 8'h10);
        cyc(2);
        chk({6'h00, light, deep}, 8'h02);
        set_in(2, 1'b1);
        set_in(2, 1'b0);
        cyc(1);
        chk({6'h00, light, deep}, 8'h00);
        wr_reg(CM2_ADDR, 8'h20);
        cyc(4);
        chk({7'h00, deep}, 8'h01);
        set_in(1, 1'b1);
        cyc(8);
        chk({6'h00, light, deep}, 8'h00);
        set_in(1, 1'b0);
        cyc(10);
        wr_reg(CM2_ADDR, 8'h10);
        cyc(2);
        rd_reg(8'h00, 8'h00);
        cyc(1);
        chk({6'h00, light, deep}, 8'h00);
        wr_reg(CM1_ADDR, 8'h40);
        recovered_master_clk_cnt(8'h18);
        wr_reg(CM1_ADDR, 8'h50);
        recovered_master_clk_cnt(8'h10);
        @(posedge mclk);
        recovered_master_clk_en <= 1'b0;
        recovered_master_clk_cnt(8'h00);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk(tune, TUNE_RST);
        rd_reg(CM2_ADDR, 8'h80);
        rd_reg(CM1_ADDR, CM1_RST);
        close_out();
    end
endmodule
